// ---- include/flag_bank_pkg.sv ----
package flag_bank_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] FLAG_ONE_OFFSET = 12'h000;
  localparam logic [11:0] FLAG_TWO_OFFSET = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h00C;
  localparam logic [11:0] MODE_CTRL_OFFSET = 12'h010;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PARALLEL_PORT_BIT = 7;
  localparam int CONVERSION_DONE_BIT = 6;
  localparam int RX_FULL_BIT = 5;
  localparam int TX_EMPTY_BIT = 4;
  localparam int SYNC_PORT_DONE_BIT = 3;
  localparam int CAPCOMP_ONE_BIT = 2;
  localparam int TIMER_TWO_MATCH_BIT = 1;
  localparam int TIMER_ONE_OVERFLOW_BIT = 0;
  localparam int COMPARATOR_CHANGE_BIT = 6;
  localparam int NVM_WRITE_DONE_BIT = 4;
  localparam int BUS_COLLISION_BIT = 3;
  localparam int LOW_VOLTAGE_BIT = 2;
  localparam int LARGE_PIN_BIT = 0;
  localparam int MCU_MODE_BIT = 1;
  localparam int CCP_MODE_LSB = 2;

  // software-writable bits of each flag register
  localparam logic [7:0] FLAG_ONE_WRITABLE = 8'hCF;
  localparam logic [7:0] FLAG_TWO_WRITABLE = 8'h5C;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic [3:0] MODE_CTRL_RESET = 4'h0;
  localparam logic [31:0] PRDATA_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CCP_CAPTURE,
    CCP_COMPARE,
    CCP_PWM,
    CCP_OFF
  } ccp_mode_t;

  typedef struct packed {
    logic parallel_port_access;
    logic conversion_done;
    logic serial_rx_loaded;
    logic serial_rx_buffer_read;
    logic serial_tx_drained;
    logic serial_tx_buffer_written;
    logic sync_port_done;
    logic capcomp_one_capture;
    logic capcomp_one_compare;
    logic timer_two_match;
    logic timer_one_overflow;
    logic comparator_change;
    logic nvm_write_done;
    logic bus_collision;
    logic sync_port_bus_master_tx;
    logic low_voltage;
  } peripheral_events_t;

  typedef struct packed {
    logic [7:0] peripheral_flag_reg_two;
    logic [7:0] peripheral_flag_reg_one;
  } flag_regs_t;

endpackage : flag_bank_pkg

// ---- rtl/peripheral_irq_flag_bank.sv ----
// Operation
// [RQ1] flags set regardless of enables
// [RQ2] software clears flag before enabling, after servicing
// [RQ3] software-cleared flags clear only by writing zero
// [RQ4] bit 7 set on parallel port access
// [RQ5] large-pin part: parallel flag only in mcu mode
// [RQ6] bit 6 set on conversion done
// [RQ7] bit 5 read-only receive full, cleared on read
// [RQ8] bit 4 read-only transmit empty, cleared on write
// [RQ9] bit 3 set when sync port finishes
// [RQ10] bit 2 capture or compare event, unused pwm
// [RQ11] bit 1 set on timer two match
// [RQ12] bit 0 set on timer one overflow
// [RQ13] reg two: comparator change, nvm done; 7,5 zero
// [RQ14] reg two bit 3 bus collision as master
// [RQ15] reg two bit 2 low voltage detected
// [RQ16] reset clears flags; writes touch writable bits only
`timescale 1ns/1ps

module peripheral_irq_flag_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral condition pulses
  input wire flag_bank_pkg::peripheral_events_t events,
  // flag state and interrupt
  output flag_bank_pkg::flag_regs_t flags,
  output logic irq
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == flag_bank_pkg::FLAG_ONE_OFFSET) ||
                (addr == flag_bank_pkg::FLAG_TWO_OFFSET) ||
                (addr == flag_bank_pkg::IRQ_STATUS_OFFSET) ||
                (addr == flag_bank_pkg::IRQ_MASK_OFFSET) ||
                (addr == flag_bank_pkg::MODE_CTRL_OFFSET);
  endfunction : is_mapped

  function automatic logic [7:0] merge_write(input logic [7:0] old_value,
                                             input logic [7:0] wr_value,
                                             input logic [7:0] writable);
    merge_write = (old_value & ~writable) | (wr_value & writable);
  endfunction : merge_write

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] flag_one;
  logic [7:0] flag_two;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [3:0] mode_ctrl;
  logic [7:0] next_flag_one;
  logic [7:0] next_flag_two;
  logic [15:0] next_irq_status;
  logic [15:0] next_irq_mask;
  logic [3:0] next_mode_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;

  logic wr_en;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic [7:0] clr_one;
  flag_bank_pkg::ccp_mode_t ccp_mode;
  logic parallel_allowed;
  logic parallel_event;
  logic capcomp_event;
  logic collision_event;
  logic wr_flag_one;
  logic wr_flag_two;
  logic wr_status;
  logic wr_mask;
  logic wr_mode;

  // a write takes effect only at the completing access edge
  assign wr_en = psel && penable && pready && pwrite && !pslverr;
  assign ccp_mode = flag_bank_pkg::ccp_mode_t'(
    mode_ctrl[flag_bank_pkg::CCP_MODE_LSB +: 2]);
  assign parallel_allowed = !mode_ctrl[flag_bank_pkg::LARGE_PIN_BIT] ||
                            mode_ctrl[flag_bank_pkg::MCU_MODE_BIT]; // [RQ5]

  // ----------------------------------------------------------------
  // register write strobes
  // ----------------------------------------------------------------
  // an access refused with an error never reaches a register
  assign wr_flag_one = wr_en && (paddr == flag_bank_pkg::FLAG_ONE_OFFSET);
  assign wr_flag_two = wr_en && (paddr == flag_bank_pkg::FLAG_TWO_OFFSET);
  assign wr_status = wr_en && (paddr == flag_bank_pkg::IRQ_STATUS_OFFSET);
  assign wr_mask = wr_en && (paddr == flag_bank_pkg::IRQ_MASK_OFFSET);
  assign wr_mode = wr_en && (paddr == flag_bank_pkg::MODE_CTRL_OFFSET);

  // ----------------------------------------------------------------
  // gated events
  // ----------------------------------------------------------------
  // capture and compare pulses share one flag; pwm and off modes drop both
  always_comb begin
    case (ccp_mode)
      flag_bank_pkg::CCP_CAPTURE: begin
        capcomp_event = events.capcomp_one_capture; // [RQ10]
      end
      flag_bank_pkg::CCP_COMPARE: begin
        capcomp_event = events.capcomp_one_compare; // [RQ10]
      end
      default: begin
        capcomp_event = 1'b0; // [RQ10]
      end
    endcase
  end

  assign parallel_event = events.parallel_port_access && parallel_allowed; // [RQ4] [RQ5]
  // a collision counts only while the sync port transmits as master
  assign collision_event = events.bus_collision && events.sync_port_bus_master_tx; // [RQ14]

  // ----------------------------------------------------------------
  // flag one set and clear terms
  // ----------------------------------------------------------------
  always_comb begin
    set_one = 8'h00;
    clr_one = 8'h00;
    // enables elsewhere never gate these sets [RQ1]
    set_one[flag_bank_pkg::PARALLEL_PORT_BIT] = parallel_event; // [RQ4]
    set_one[flag_bank_pkg::CONVERSION_DONE_BIT] = events.conversion_done; // [RQ6]
    set_one[flag_bank_pkg::RX_FULL_BIT] = events.serial_rx_loaded; // [RQ7]
    set_one[flag_bank_pkg::TX_EMPTY_BIT] = events.serial_tx_drained; // [RQ8]
    set_one[flag_bank_pkg::SYNC_PORT_DONE_BIT] = events.sync_port_done; // [RQ9]
    set_one[flag_bank_pkg::CAPCOMP_ONE_BIT] = capcomp_event; // [RQ10]
    set_one[flag_bank_pkg::TIMER_TWO_MATCH_BIT] = events.timer_two_match; // [RQ11]
    set_one[flag_bank_pkg::TIMER_ONE_OVERFLOW_BIT] = events.timer_one_overflow; // [RQ12]
    // buffer-side clears of the read-only bits
    clr_one[flag_bank_pkg::RX_FULL_BIT] = events.serial_rx_buffer_read; // [RQ7]
    clr_one[flag_bank_pkg::TX_EMPTY_BIT] = events.serial_tx_buffer_written; // [RQ8]
  end

  // ----------------------------------------------------------------
  // flag two set terms
  // ----------------------------------------------------------------
  always_comb begin
    set_two = 8'h00;
    set_two[flag_bank_pkg::COMPARATOR_CHANGE_BIT] = events.comparator_change; // [RQ13]
    set_two[flag_bank_pkg::NVM_WRITE_DONE_BIT] = events.nvm_write_done; // [RQ13]
    set_two[flag_bank_pkg::BUS_COLLISION_BIT] = collision_event; // [RQ14]
    set_two[flag_bank_pkg::LOW_VOLTAGE_BIT] = events.low_voltage; // [RQ15]
  end

  // ----------------------------------------------------------------
  // flag register next values
  // ----------------------------------------------------------------
  always_comb begin
    next_flag_one = flag_one & ~clr_one; // [RQ7] [RQ8]
    next_flag_two = flag_two;
    if (wr_flag_one) begin
      next_flag_one = merge_write(next_flag_one, pwdata[7:0],
                                  flag_bank_pkg::FLAG_ONE_WRITABLE); // [RQ3] [RQ16]
    end
    if (wr_flag_two) begin
      next_flag_two = merge_write(flag_two, pwdata[7:0],
                                  flag_bank_pkg::FLAG_TWO_WRITABLE); // [RQ3] [RQ16]
    end
    // a set in the same cycle as a clear wins [RQ1] [RQ3]
    next_flag_one = next_flag_one | set_one;
    next_flag_two = (next_flag_two | set_two) & flag_bank_pkg::FLAG_TWO_WRITABLE; // [RQ13]
  end

  // ----------------------------------------------------------------
  // interrupt status and mask next values
  // ----------------------------------------------------------------
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr_status) begin
      next_irq_status = irq_status & ~pwdata[15:0];
    end
    if (wr_mask) begin
      next_irq_mask = pwdata[15:0];
    end
    // an event in the clearing cycle keeps its status bit
    next_irq_status = next_irq_status | {set_two, set_one};
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // ----------------------------------------------------------------
  // mode control next value
  // ----------------------------------------------------------------
  always_comb begin
    next_mode_ctrl = mode_ctrl;
    if (wr_mode) begin
      next_mode_ctrl = pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // apb answer: one wait-free access cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !is_mapped(paddr);
    next_prdata = prdata;
    if (psel && !penable) begin
      case (paddr)
        flag_bank_pkg::FLAG_ONE_OFFSET: begin
          next_prdata = {24'h000000, flag_one};
        end
        flag_bank_pkg::FLAG_TWO_OFFSET: begin
          next_prdata = {24'h000000, flag_two};
        end
        flag_bank_pkg::IRQ_STATUS_OFFSET: begin
          next_prdata = {16'h0000, irq_status};
        end
        flag_bank_pkg::IRQ_MASK_OFFSET: begin
          next_prdata = {16'h0000, irq_mask};
        end
        flag_bank_pkg::MODE_CTRL_OFFSET: begin
          next_prdata = {28'h0000000, mode_ctrl};
        end
        default: begin
          next_prdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flag registers and their output copy
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_one <= flag_bank_pkg::FLAG_RESET; // [RQ16]
      flag_two <= flag_bank_pkg::FLAG_RESET; // [RQ16]
      flags <= '0;
    end else begin
      flag_one <= next_flag_one;
      flag_two <= next_flag_two;
      flags <= {next_flag_two, next_flag_one};
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= flag_bank_pkg::IRQ_RESET;
      irq_mask <= flag_bank_pkg::IRQ_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  // ----------------------------------------------------------------
  // interrupt output register
  // ----------------------------------------------------------------
  // registered from the next status, so it never glitches and never lags it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // mode control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ctrl <= flag_bank_pkg::MODE_CTRL_RESET;
    end else begin
      mode_ctrl <= next_mode_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // apb answer registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= flag_bank_pkg::PRDATA_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : peripheral_irq_flag_bank

// ---- bench/event_source.sv ----
`timescale 1ns/1ps
module event_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // stimulus request
  input wire logic fire,
  input wire logic [15:0] pattern,
  input wire logic master_tx,
  // condition pulses
  output flag_bank_pkg::peripheral_events_t events
);
  // pulses last one cycle; the master level follows its request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      events <= '0;
    end else begin
      events <= ((fire ? pattern : 16'h0000) & 16'hFFFD) | {14'h0000, master_tx, 1'b0};
    end
  end
endmodule : event_source

// ---- bench/flag_bank_props.sv ----
`timescale 1ns/1ps
module flag_bank_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // events and flags
  input wire flag_bank_pkg::peripheral_events_t events,
  input wire flag_bank_pkg::flag_regs_t flags,
  input wire logic irq
);
  logic wr_one;
  assign wr_one = psel && penable && pwrite && paddr == 12'h000;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    pready ##1 !pready;
  endsequence
  apb_pulse_a: assert property (setup_s |=> access_s) else $error("pready not one cycle");
  ovf_set_a: assert property (events.timer_one_overflow |=> flags[0])
    else $error("overflow flag not set");
  conv_set_a: assert property (events.conversion_done |=> flags[6])
    else $error("conversion flag not set");
  sync_set_a: assert property (events.sync_port_done |=> flags[3])
    else $error("sync port flag not set");
  match_set_a: assert property (events.timer_two_match |=> flags[1])
    else $error("match flag not set");
  rx_full_a: assert property (events.serial_rx_loaded |=> flags[5])
    else $error("rx full flag not set");
  tx_clear_a: assert property (events.serial_tx_buffer_written && !events.serial_tx_drained
    |=> !flags[4]) else $error("tx empty flag not cleared");
  coll_set_a: assert property (events.bus_collision && events.sync_port_bus_master_tx
    |=> flags[11]) else $error("collision flag not set");
  nvm_set_a: assert property (events.nvm_write_done |=> flags[12])
    else $error("nvm write flag not set");
  cmp_set_a: assert property (events.comparator_change |=> flags[14])
    else $error("comparator flag not set");
  low_volt_a: assert property (events.low_voltage |=> flags[10])
    else $error("low voltage flag not set");
  flag_hold_a: assert property (flags[0] && !wr_one |=> flags[0])
    else $error("flag dropped without write");
  zero_bits_a: assert property (!flags[15] && !flags[13])
    else $error("unused bits not zero");
endmodule : flag_bank_props
bind peripheral_irq_flag_bank flag_bank_props u_flag_bank_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .flags(flags),
  .irq(irq));

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, mtx = 1, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] pat = 0;
  logic pready, pslverr;
  flag_bank_pkg::peripheral_events_t events;
  flag_bank_pkg::flag_regs_t flags;
  logic [31:0] exp_q[$];
  int failures = 0, cmp_count = 0, cyc = 0, seed = 68985;
  logic [3:0] md[8] = '{4'h0, 4'h4, 4'h4, 4'h8, 4'h1, 4'h3, 4'h0, 4'hC};
  logic [15:0] pv[8] = '{16'h0080, 16'h0080, 16'h0100, 16'h0180, 16'h8000, 16'h8000, 16'h0004,
    16'h0180};
  logic [15:0] ev[8] = '{16'h0, 16'h0004, 16'h0, 16'h0, 16'h0, 16'h0080, 16'h0, 16'h0};
  always #5 pclk = ~pclk;
  peripheral_irq_flag_bank u_peripheral_irq_flag_bank (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events), .flags(flags),
    .irq(irq));
  event_source u_event_source (.pclk(pclk), .presetn(presetn), .fire(fire), .pattern(pat),
    .master_tx(mtx), .events(events));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    // only pready or the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task pulse(input logic [15:0] v);
    @(posedge pclk);
    fire <= 1; pat <= v;
    @(posedge pclk);
    fire <= 0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // read data is checked against the oldest note
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) chk("prdata", exp_q.pop_front(), prdata);
    if (psel && penable && pready === 1'b1) chk("pslverr", paddr == 12'h020, pslverr);
    if (cyc == 8000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    logic [15:0] v;
    logic [7:0] e1, e2;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    apb(0, 12'h004, 0);
    apb(0, 12'h020, 0);
    apb(1, 12'h000, 32'hFF); apb(1, 12'h004, 32'hFF);
    apb(0, 12'h000, 32'hCF); apb(0, 12'h004, 32'h5C);
    apb(1, 12'h000, 0); apb(1, 12'h004, 0);
    $display("registers test done");
    repeat (12) begin
      v = 16'($random(seed)) & 16'hEB7D;
      e1 = {v[15:13], v[11], v[9:8], v[6:5]};
      e2 = {1'b0, v[4], 1'b0, v[3:2], v[0], 2'b00};
      pulse(v);
      chk("flags", {e2, e1}, flags);
      apb(0, 12'h000, e1);
      apb(0, 12'h004, e2);
      apb(1, 12'h000, 0); apb(1, 12'h004, 0);
      apb(0, 12'h000, {v[13], v[11], 4'h0});
      pulse(16'h1400);
      apb(0, 12'h000, 0);
    end
    $display("event test done");
    for (int i = 0; i < 8; i++) begin
      mtx <= (i != 6);
      apb(1, 12'h010, md[i]);
      pulse(pv[i]);
      apb(0, 12'h000, ev[i][7:0]);
      apb(0, 12'h004, ev[i][15:8]);
      apb(1, 12'h000, 0);
    end
    mtx <= 1;
    apb(1, 12'h010, 0);
    $display("mode test done");
    apb(1, 12'h000, 0); apb(1, 12'h008, 32'hFFFF); apb(1, 12'h00C, 32'h0002);
    pulse(16'h0020);
    chk("irq", 0, irq);
    apb(1, 12'h00C, 32'h0001);
    repeat (2) @(posedge pclk);
    chk("irq", 1, irq);
    apb(1, 12'h008, 32'h0001);
    repeat (2) @(posedge pclk);
    chk("irq", 0, irq);
    $display("interrupt test done");
    report_and_stop();
  end
endmodule : tb_top
